// ==== core/pmctl_top.v ====
/*
 * two top-level control registers of a power-management device: rail lockout,
 * thermal shutdown and die warning thresholds; operating mode, software reset
 * and on-key long-press timer.
 * assumes a byte register port from the device's serial target logic on the
 * same clock (one-cycle write and read strobes) and mode-select pins from outside.
 */
// Functional notes
// - bits 7:6 of the threshold register select rail lockout 2.4 V to 2.7 V and reset to 11.
// - bits 4:2 select thermal shutdown 95 to 125 degrees in 5 degree steps, reset 011, code 111 reserved.
// - bits 1:0 select die warning 75 to 90 degrees and reset to 10.
// - the applied mode comes from the register bits or from the pins per the pin-select control.
// - with pin-select at 0 the applied mode equals the two register mode bits, both resetting to 0.
// - writing 1 to bit 2 of the mode register restores all other bits to default and cycles the regulators.
// - the software reset bit clears itself so that it always reads 0.
// - bits 1:0 of the mode register select a 4 to 16 s long-press time and reset to 01.
`timescale 1ns/1ps
`default_nettype none
`include "pmctl_regs.vh"
module pmctl_top #(
	parameter CYCLE_CLKS = 16
)(
	input  wire        i_clk_sys,
	input  wire        i_reset_n,
	input  wire        i_clk_en,
	input  wire [7:0]  i_reg_addr,
	input  wire [7:0]  i_reg_wdata,
	input  wire        i_reg_wr,
	input  wire        i_reg_rd,
	input  wire        i_mode_from_pins_enable,
	input  wire [1:0]  i_mode_select_pin,
	output reg  [7:0]  o_reg_rdata,
	output reg         o_reg_rvalid,
	output reg  [1:0]  o_system_rail_lockout_select,
	output reg  [2:0]  o_thermal_shutdown_select,
	output reg         o_thermal_shutdown_reserved,
	output reg  [1:0]  o_die_warning_select,
	output reg  [1:0]  o_applied_mode,
	output reg  [1:0]  o_key_long_press_timer,
	output reg         o_regulator_cycle
);
	reg  [7:0] thresh_r;
	reg  [7:0] modekey_r;
	reg  [1:0] pin_meta_r;
	reg  [1:0] pin_sync_r;
	reg        sel_meta_r;
	reg        sel_sync_r;
	reg        soft_reset_r;
	wire       cycle_active;
	wire       wr_thresh;
	wire       wr_modekey;
	wire       soft_req;
	wire [1:0] reg_mode;

	// output reset values are cut from the register defaults so the two cannot drift apart
	localparam [7:0] THRESH_DEF      = `PMCTL_THRESH_RESET;
	localparam [7:0] MODEKEY_DEF     = `PMCTL_MODEKEY_RESET;
	localparam [7:0] SOFT_RESET_MASK = 8'h01 << `PMCTL_SOFT_RESET_BIT;
	localparam [1:0] LOCKOUT_DEF     = THRESH_DEF[`PMCTL_LOCKOUT_HI:`PMCTL_LOCKOUT_LO];
	localparam [2:0] TSHUT_DEF       = THRESH_DEF[`PMCTL_TSHUT_HI:`PMCTL_TSHUT_LO];
	localparam [1:0] TWARN_DEF       = THRESH_DEF[`PMCTL_TWARN_HI:`PMCTL_TWARN_LO];
	localparam [1:0] KEYTMR_DEF      = MODEKEY_DEF[`PMCTL_KEYTMR_HI:`PMCTL_KEYTMR_LO];
	localparam [1:0] MODE_DEF        = {MODEKEY_DEF[`PMCTL_MODE_UPPER_BIT], MODEKEY_DEF[`PMCTL_MODE_LOWER_BIT]};

	// one decode serves both the write strobes and the read mux
	function addr_is_thresh;
		input [7:0] addr;
		begin
			addr_is_thresh = (addr == `PMCTL_ADDR_THRESH);
		end
	endfunction

	function addr_is_modekey;
		input [7:0] addr;
		begin
			addr_is_modekey = (addr == `PMCTL_ADDR_MODEKEY);
		end
	endfunction

	function [2:0] tshut_field;
		input [7:0] thresh;
		begin
			tshut_field = thresh[`PMCTL_TSHUT_HI:`PMCTL_TSHUT_LO];
		end
	endfunction

	function [1:0] mode_code;
		input [7:0] modekey;
		begin
			mode_code = {modekey[`PMCTL_MODE_UPPER_BIT], modekey[`PMCTL_MODE_LOWER_BIT]};
		end
	endfunction

	assign wr_thresh  = i_reg_wr && addr_is_thresh(i_reg_addr);
	assign wr_modekey = i_reg_wr && addr_is_modekey(i_reg_addr);
	assign soft_req   = wr_modekey && i_reg_wdata[`PMCTL_SOFT_RESET_BIT];
	assign reg_mode   = mode_code(modekey_r);

	// pins and the pin-select level come from outside this clock domain
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pin_meta_r <= 2'h0;
			pin_sync_r <= 2'h0;
			sel_meta_r <= 1'b0;
			sel_sync_r <= 1'b0;
		end
		else if (i_clk_en)
		begin
			pin_meta_r <= i_mode_select_pin;
			pin_sync_r <= pin_meta_r;
			sel_meta_r <= i_mode_from_pins_enable;
			sel_sync_r <= sel_meta_r;
		end
	end

	// a soft reset write restores defaults; the rest of that byte is discarded
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			thresh_r     <= `PMCTL_THRESH_RESET;
			modekey_r    <= `PMCTL_MODEKEY_RESET;
			soft_reset_r <= 1'b0;
		end
		else if (i_clk_en)
		begin
			soft_reset_r <= soft_req;
			if (soft_req)
			begin
				thresh_r  <= `PMCTL_THRESH_RESET;
				modekey_r <= `PMCTL_MODEKEY_RESET;
			end
			else
			begin
				if (wr_thresh)
					thresh_r <= i_reg_wdata;
				if (wr_modekey)
					modekey_r <= i_reg_wdata & ~SOFT_RESET_MASK;
			end
		end
	end

	pmctl_cycle_timer #(
		.CNT_W  (16),
		.CYCLES (CYCLE_CLKS)
	) u_cycle (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_clk_en  (i_clk_en),
		.i_start   (soft_reset_r),
		.o_active  (cycle_active)
	);

	// read data stands until the next read; valid is a one-cycle pulse
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd)
			begin
				if (addr_is_thresh(i_reg_addr))
					o_reg_rdata <= thresh_r;
				else if (addr_is_modekey(i_reg_addr))
					o_reg_rdata <= modekey_r;
				else
					o_reg_rdata <= 8'h00;
			end
		end
	end

	// threshold selections towards the comparators
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_system_rail_lockout_select <= LOCKOUT_DEF;
			o_thermal_shutdown_select    <= TSHUT_DEF;
			o_thermal_shutdown_reserved  <= 1'b0;
			o_die_warning_select         <= TWARN_DEF;
		end
		else if (i_clk_en)
		begin
			o_system_rail_lockout_select <= thresh_r[`PMCTL_LOCKOUT_HI:`PMCTL_LOCKOUT_LO];
			o_thermal_shutdown_select    <= tshut_field(thresh_r);
			// reserved code is flagged, not remapped, so the analog side decides
			o_thermal_shutdown_reserved  <= (tshut_field(thresh_r) == `PMCTL_TSHUT_RSVD_CODE);
			o_die_warning_select         <= thresh_r[`PMCTL_TWARN_HI:`PMCTL_TWARN_LO];
		end
	end

	// applied mode, key timer and regulator cycle request
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_applied_mode         <= MODE_DEF;
			o_key_long_press_timer <= KEYTMR_DEF;
			o_regulator_cycle      <= 1'b0;
		end
		else if (i_clk_en)
		begin
			// pin mode waits for both synchroniser stages, so a pin change lands three edges late
			if (sel_sync_r)
				o_applied_mode <= pin_sync_r;
			else
				o_applied_mode <= reg_mode;
			o_key_long_press_timer <= modekey_r[`PMCTL_KEYTMR_HI:`PMCTL_KEYTMR_LO];
			o_regulator_cycle      <= cycle_active;
		end
	end
endmodule // pmctl_top
`default_nettype wire

// ==== core/pmctl_regs.vh ====
/*
 * register offsets, field positions, reset values and timing counts of the
 * top-level control register pair.
 * assumes the includer has a 25 MHz system clock.
 */
`ifndef PMCTL_REGS_VH
`define PMCTL_REGS_VH

`define PMCTL_ADDR_THRESH       8'h0b
`define PMCTL_ADDR_MODEKEY      8'h0c

`define PMCTL_THRESH_RESET      8'hce
`define PMCTL_MODEKEY_RESET     8'h01

`define PMCTL_LOCKOUT_HI        7
`define PMCTL_LOCKOUT_LO        6
`define PMCTL_TSHUT_HI          4
`define PMCTL_TSHUT_LO          2
`define PMCTL_TWARN_HI          1
`define PMCTL_TWARN_LO          0

`define PMCTL_MODE_UPPER_BIT    4
`define PMCTL_MODE_LOWER_BIT    3
`define PMCTL_SOFT_RESET_BIT    2
`define PMCTL_KEYTMR_HI         1
`define PMCTL_KEYTMR_LO         0

`define PMCTL_TSHUT_RSVD_CODE   3'h7

`define PMCTL_CYCLE_OFF_CLKS    16'h0010

`endif

// ==== core/pmctl_cycle_timer.v ====
/*
 * one-shot timer that holds the regulator cycle request for a fixed count.
 * assumes a start pulse from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pmctl_cycle_timer #(
	parameter CNT_W  = 16,
	parameter CYCLES = 16
)(
	input  wire             i_clk_sys,
	input  wire             i_reset_n,
	input  wire             i_clk_en,
	input  wire             i_start,
	output reg              o_active
);
	reg [CNT_W-1:0] count_r;

	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			count_r  <= {CNT_W{1'b0}};
			o_active <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (i_start)
			begin
				count_r  <= CYCLES[CNT_W-1:0];
				o_active <= 1'b1;
			end
			else if (count_r != {CNT_W{1'b0}})
			begin
				count_r  <= count_r - {{(CNT_W-1){1'b0}}, 1'b1};
				o_active <= (count_r != {{(CNT_W-1){1'b0}}, 1'b1});
			end
		end
	end
endmodule // pmctl_cycle_timer
`default_nettype wire

// ==== bench/pmctl_sva.sv ====
/* port assertions for pmctl_top; assumes one clock and async low reset */
`timescale 1ns/1ps
`default_nettype none
module pmctl_sva #(
	parameter CYCLE_CLKS = 16
)(
	input wire logic       i_clk_sys,
	input wire logic       i_reset_n,
	input wire logic       i_clk_en,
	input wire logic       i_reg_wr,
	input wire logic       i_reg_rd,
	input wire logic       i_mode_from_pins_enable,
	input wire logic       o_thermal_shutdown_reserved,
	input wire logic       o_regulator_cycle,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic [1:0] i_mode_select_pin,
	input wire logic [1:0] o_system_rail_lockout_select,
	input wire logic [1:0] o_die_warning_select,
	input wire logic [1:0] o_applied_mode,
	input wire logic [1:0] o_key_long_press_timer,
	input wire logic [2:0] o_thermal_shutdown_select
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	wire w0 = i_clk_en & i_reg_wr & (i_reg_addr == 8'h0b);
	wire wc = i_clk_en & i_reg_wr & (i_reg_addr == 8'h0c) & !i_mode_from_pins_enable;
	// length of the current high run of the regulator cycle request
	logic [15:0] cyc_run_r;
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
		if (!i_reset_n)
			cyc_run_r <= 16'h0000;
		else if (i_clk_en)
			cyc_run_r <= o_regulator_cycle ? cyc_run_r + 16'h0001 : 16'h0000;
	sequence s_defaults;
		o_system_rail_lockout_select == 2'h3 && o_thermal_shutdown_select == 3'h3 && o_die_warning_select == 2'h2
		&& o_applied_mode == 2'h0 && o_key_long_press_timer == 2'h1;
	endsequence
	AST_LOCKOUT: assert property (w0 |-> ##2 o_system_rail_lockout_select == $past(i_reg_wdata[7:6], 2))
		else $error("lockout field");
	AST_TSHUT: assert property (w0 |-> ##2 o_thermal_shutdown_select == $past(i_reg_wdata[4:2], 2))
		else $error("shutdown field");
	AST_WARN: assert property (w0 |-> ##2 o_die_warning_select == $past(i_reg_wdata[1:0], 2))
		else $error("warning field");
	AST_RSVFLAG: assert property (o_thermal_shutdown_reserved == (o_thermal_shutdown_select == 3'h7))
		else $error("reserved flag");
	AST_MODE: assert property (wc && !i_reg_wdata[2] |-> ##2 o_applied_mode == $past(i_reg_wdata[4:3], 2))
		else $error("register mode");
	AST_KEY: assert property (wc && !i_reg_wdata[2] |-> ##2 o_key_long_press_timer == $past(i_reg_wdata[1:0], 2))
		else $error("key timer");
	AST_SRST: assert property (wc && i_reg_wdata[2] |-> ##2 s_defaults ##1 o_regulator_cycle [*2])
		else $error("soft reset");
	AST_SRREAD: assert property (i_clk_en && i_reg_rd && i_reg_addr == 8'h0c |=> !o_reg_rdata[2])
		else $error("reset bit read");
	AST_PINS: assert property ((i_mode_from_pins_enable && $stable(i_mode_select_pin)) [*4]
		|-> o_applied_mode == i_mode_select_pin)
		else $error("pin mode");
	AST_CYCLE_LEN: assert property ($fell(o_regulator_cycle) |-> cyc_run_r == CYCLE_CLKS)
		else $error("cycle length");
endmodule // pmctl_sva
bind pmctl_top pmctl_sva #(.CYCLE_CLKS(CYCLE_CLKS)) pmctl_sva_inst(.*);
`default_nettype wire

// ==== bench/pmctl_host.sv ====
/* host model on the register port; assumes rvalid one cycle after the read */
`timescale 1ns/1ps
`default_nettype none
module pmctl_host(
	input  wire logic       i_clk_sys,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid,
	output var  logic [7:0] o_addr,
	output var  logic [7:0] o_wdata,
	output var  logic       o_wr,
	output var  logic       o_rd
);
	initial {o_addr, o_wdata, o_wr, o_rd} = 18'h0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys) #1;
		{o_addr, o_wdata, o_wr} = {a, d, 1'b1};
		@(posedge i_clk_sys) #1;
		o_wr = 1'b0;
		o_wdata = ~d; // stale data must not look valid
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge i_clk_sys) #1;
		{o_addr, o_rd} = {a, 1'b1};
		@(posedge i_clk_sys) #1;
		o_rd = 1'b0;
		q = i_rvalid ? i_rdata : 8'hxx;
	endtask
endmodule // pmctl_host
`default_nettype wire

// ==== bench/pmctl_top_test.sv ====
/* bench for pmctl_top; assumes pmctl_host drives the register port */
`timescale 1ns/1ps
`default_nettype none
module pmctl_top_test;
	logic       i_clk_sys = 0, i_reset_n = 0, i_clk_en = 1, i_mode_from_pins_enable = 0;
	logic       i_reg_wr, i_reg_rd, o_reg_rvalid, o_thermal_shutdown_reserved, o_regulator_cycle;
	logic [1:0] i_mode_select_pin = 0, o_system_rail_lockout_select, o_die_warning_select;
	logic [1:0] o_applied_mode, o_key_long_press_timer;
	logic [2:0] o_thermal_shutdown_select;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, q, v;
	int         err_count = 0, checks_done = 0, cyc = 0;
	always #20 i_clk_sys = ~i_clk_sys;
	pmctl_top #(.CYCLE_CLKS(4)) pmctl_top_inst(.*);
	pmctl_host pmctl_host_inst(.i_clk_sys(i_clk_sys), .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid),
		.o_addr(i_reg_addr), .o_wdata(i_reg_wdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd));
	task chk(input logic [11:0] g, input logic [11:0] e);
		checks_done++;
		if (g !== e)
			$display("unexpected %0t got %h want %h", $time, g, e);
		if (g !== e)
			err_count++;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		pmctl_host_inst.rd(a, q);
		chk(q, e);
	endtask
	task wr2(input logic [7:0] a, input logic [7:0] d);
		pmctl_host_inst.wr(a, d);
		repeat (2) @(posedge i_clk_sys);
		#1;
	endtask
	task finish_test;
		$display("mismatches %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge i_clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
			err_count++;
		if (cyc == 3000)
			finish_test;
	end
	initial
	begin
		repeat (6) @(posedge i_clk_sys);
		#1 i_reset_n = 1;
		rchk(8'h0b, 8'hce);
		rchk(8'h0c, 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			v = {i[1:0], 1'b1, i[2:0], ~i[1:0]};
			wr2(8'h0b, v);
			chk({o_system_rail_lockout_select, o_thermal_shutdown_reserved, o_thermal_shutdown_select,
				o_die_warning_select}, {v[7:6], i == 7, v[4:0]});
			rchk(8'h0b, v);
		end
		for (int m = 0; m < 4; m++)
		begin
			v = {3'h5, m[1:0], 1'b0, m[1:0]};
			wr2(8'h0c, v);
			chk({o_applied_mode, o_key_long_press_timer}, {m[1:0], m[1:0]});
			rchk(8'h0c, v);
		end
		rchk(8'h20, 8'h00);
		wr2(8'h0c, 8'hfc);
		chk({o_system_rail_lockout_select, o_thermal_shutdown_select, o_die_warning_select,
			o_applied_mode, o_key_long_press_timer, o_regulator_cycle}, 12'hdc3);
		rchk(8'h0b, 8'hce);
		rchk(8'h0c, 8'h01);
		chk(o_regulator_cycle, 1'b0);
		{i_mode_from_pins_enable, i_mode_select_pin} = 3'h6;
		repeat (5) @(posedge i_clk_sys);
		#1 chk(o_applied_mode, 2'h2);
		finish_test;
	end
endmodule // pmctl_top_test
`default_nettype wire
